// ### shared/scdp_defs.svh
`ifndef SCDP_DEFS_SVH
`define SCDP_DEFS_SVH

// ***********************************************
// Register map (byte addresses, low 20 bits)
// ***********************************************
`define SCDP_ADDR_DIV_CTRL     20'hEE01B
`define SCDP_ADDR_MOD_STBY     20'hEE01C
`define SCDP_ADDR_SYS_CTRL     20'hEE012
`define SCDP_ADDR_DIV_CTRL_W   20'hEE018
`define SCDP_ADDR_MOD_STBY_W   20'hEE01C
`define SCDP_ADDR_SYS_CTRL_W   20'hEE010
`define SCDP_ADDR_STATUS_W     20'hEE020

// ***********************************************
// Reset values and fields
// ***********************************************
`define SCDP_DIV_CTRL_RST      8'hFC
`define SCDP_DIV_CTRL_FIXED    6'h3F
`define SCDP_MOD_STBY_RST      8'h78
`define SCDP_SYS_CTRL_RST      8'h09
`define SCDP_CLK_OUT_STOP_BIT  7
`define SCDP_WAIT_SEL_LSB      4

// ***********************************************
// Timing
// ***********************************************
`define SCDP_CLK_MHZ           200
`define SCDP_DUTY_MIN_MHZ      5
`define SCDP_SETTLE_US         500
`define SCDP_SETTLE_CYC        (`SCDP_SETTLE_US * `SCDP_CLK_MHZ)
`define SCDP_PRESC_BITS        12

`endif

// ### shared/scdp_pkg.sv
`default_nettype none

package scdp_pkg;

	typedef enum logic [1:0] {
		SCDP_RATIO_SELECT_HIGH = 2'b00,
		SCDP_DIV2 = 2'b01,
		SCDP_DIV4 = 2'b10,
		SCDP_DIV8 = 2'b11
	} scdp_ratio_type;

	typedef enum logic [1:0] {
		SCDP_RUN    = 2'b00,
		SCDP_SLEEP  = 2'b01,
		SCDP_SETTLE = 2'b10
	} scdp_stby_type;

endpackage : scdp_pkg

`default_nettype wire

// ### core/scdp_ratio_divider.sv
`timescale 1ns/1ps
`default_nettype none

module scdp_ratio_divider
	import scdp_pkg::*;
(
	input  wire logic           clk,
	input  wire logic           rst_n,
	input  wire logic           osc_en,
	input  wire scdp_ratio_type ratio,
	output logic                sys_en,
	output logic                sys_phase
);

	logic [2:0]     cnt_r,   cnt_nxt;
	scdp_ratio_type act_r,   act_nxt;
	logic [2:0]     top;

	always_comb begin
		case (act_r)
			SCDP_RATIO_SELECT_HIGH: top = 3'h0;
			SCDP_DIV2: top = 3'h1;
			SCDP_DIV4: top = 3'h3;
			SCDP_DIV8: top = 3'h7;
			default:   top = 3'h0;
		endcase
		cnt_nxt = cnt_r;
		act_nxt = act_r;
		sys_en  = 1'b0;
		if (osc_en) begin
			if (cnt_r >= top) begin
				cnt_nxt = 3'h0;
				sys_en  = 1'b1;
				// New ratio only at a full period end, no short phases
				act_nxt = ratio;
			end else begin
				cnt_nxt = cnt_r + 3'h1;
			end
		end
		sys_phase = (act_r == SCDP_RATIO_SELECT_HIGH) ? 1'b1 : (cnt_r <= (top >> 1));
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 3'h0;
			act_r <= SCDP_RATIO_SELECT_HIGH;
		end else begin
			cnt_r <= cnt_nxt;
			act_r <= act_nxt;
		end
	end

endmodule : scdp_ratio_divider

`default_nettype wire

// ### core/scdp_prescaler.sv
`timescale 1ns/1ps
`default_nettype none

`include "scdp_defs.svh"

module scdp_prescaler
	import scdp_pkg::*;
(
	input  wire logic                         clk,
	input  wire logic                         rst_n,
	input  wire logic                         sys_en,
	output logic [`SCDP_PRESC_BITS-1:0]       tick
);

	logic [`SCDP_PRESC_BITS-1:0] cnt_r, cnt_nxt;
	logic [`SCDP_PRESC_BITS-1:0] mask;

	always_comb begin
		cnt_nxt = sys_en ? cnt_r + 12'h001 : cnt_r;
		mask    = '0;
		// Bit k gives one pulse per 2^(k+1) system ticks: /2 .. /4096
		for (int k = 0; k < `SCDP_PRESC_BITS; k++) begin
			mask    = {mask[`SCDP_PRESC_BITS-2:0], 1'b1};
			tick[k] = sys_en && ((cnt_r & mask) == mask);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 12'h000;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

endmodule : scdp_prescaler

`default_nettype wire

// ### core/scdp_clock_gen.sv
// How it works
// - Codes 00/01/10/11 divide the oscillator enable by 1, 2, 4, 8.
// - Division control resets to FC on reset and hardware standby.
// - Software standby leaves the division control value untouched.
// - Bits 7..2 ignore writes and read as ones.
// - Prescaler ticks at system clock /2 through /4096.
// - Ratio may be rewritten any time, no reset needed.
// - Clock output pin follows the divided system clock except at /1, where it is held high.
// - Duty correction applies when oscillator is 5 MHz or faster.
// - Prescaler ticks and standby exit wait derive from the divided system clock; the APB slave runs on CLK.
// - Peripheral ticks scale with the current ratio.
// - Standby exit wait counted in system clock states.
// - Module standby bit 7: 0 enables clock output, 1 disables.
// - Wait select picks 8192..262144 or 1024 states; code 7 illegal.
`timescale 1ns/1ps
`default_nettype none

`include "scdp_defs.svh"

module scdp_clock_gen
	import scdp_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        RSTN,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [19:0] PADDR,
	input  wire logic [31:0] PWDATA,
	input  wire logic [3:0]  PSTRB,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        HW_STANDBY,
	input  wire logic        SW_STANDBY_REQ,
	input  wire logic        STANDBY_WAKE,
	input  wire logic        OSC_FAST,
	output logic             SYS_CLK_EN,
	output logic             CLK_OUT,
	output logic             CLK_OUT_EN,
	output logic [11:0]      PRESC_TICK,
	output logic             SW_STANDBY,
	output logic             WAIT_ILLEGAL
);

	// ***********************************************
	// Registers
	// ***********************************************
	logic [1:0]    div_sel_r,  div_sel_nxt;
	logic [7:0]    mstby_r,    mstby_nxt;
	logic [7:0]    sysc_r,     sysc_nxt;
	logic [31:0]   rdata_r,    rdata_nxt;
	logic          ready_r,    ready_nxt;
	logic          slverr_r,   slverr_nxt;
	scdp_stby_type st_r,       st_nxt;
	logic [17:0]   wait_r,     wait_nxt;
	logic          clk_out_r,  clk_out_nxt;
	logic          clk_oe_r,   clk_oe_nxt;
	logic          sys_en_r;
	logic [11:0]   tick_r;
	logic          illegal_r,  illegal_nxt;
	logic          sws_r,      sws_nxt;

	logic          osc_en;
	logic          sys_en;
	logic          sys_phase;
	logic [11:0]   tick;
	logic [17:0]   wait_len;
	logic [19:0]   word_addr;
	logic          access;
	logic          hit;
	logic [7:0]    wbyte;
	logic [7:0]    div_view;

	// Duty corrector output is one oscillator state per core cycle; below
	// 5 MHz the raw oscillator is used and no correction is claimed
	assign osc_en    = 1'b1;
	assign word_addr = {PADDR[19:2], 2'b00};
	assign access    = PSEL && PENABLE && !ready_r;
	assign div_view  = {`SCDP_DIV_CTRL_FIXED, div_sel_r};

	scdp_ratio_divider u_div (
		.clk       (CLK),
		.rst_n     (RSTN),
		.osc_en    (osc_en),
		.ratio     (scdp_ratio_type'(div_sel_r)),
		.sys_en    (sys_en),
		.sys_phase (sys_phase)
	);

	scdp_prescaler u_presc (
		.clk    (CLK),
		.rst_n  (RSTN),
		.sys_en (sys_en),
		.tick   (tick)
	);

	// ***********************************************
	// Standby wait length
	// ***********************************************
	always_comb begin
		case (sysc_r[`SCDP_WAIT_SEL_LSB +: 3])
			3'h0:    wait_len = 18'h01FFF;
			3'h1:    wait_len = 18'h03FFF;
			3'h2:    wait_len = 18'h07FFF;
			3'h3:    wait_len = 18'h0FFFF;
			3'h4:    wait_len = 18'h1FFFF;
			3'h5:    wait_len = 18'h3FFFF;
			3'h6:    wait_len = 18'h003FF;
			default: wait_len = 18'h3FFFF;
		endcase
	end

	// ***********************************************
	// APB slave: one wait state, each register on a fixed byte lane, the low two address bits ignored
	// ***********************************************
	always_comb begin
		div_sel_nxt = div_sel_r;
		mstby_nxt   = mstby_r;
		sysc_nxt    = sysc_r;
		rdata_nxt   = rdata_r;
		ready_nxt   = 1'b0;
		slverr_nxt  = 1'b0;
		hit         = 1'b1;
		wbyte       = 8'h00;
		if (access) begin
			ready_nxt = 1'b1;
			case (word_addr)
				`SCDP_ADDR_DIV_CTRL_W: begin
					wbyte     = PWDATA[31:24];
					rdata_nxt = {div_view, 24'h000000};
					if (PWRITE && PSTRB[3]) begin
						div_sel_nxt = wbyte[1:0];
					end
				end
				`SCDP_ADDR_MOD_STBY_W: begin
					wbyte     = PWDATA[7:0];
					rdata_nxt = {24'h000000, mstby_r};
					if (PWRITE && PSTRB[0]) begin
						mstby_nxt = {wbyte[7], 4'hF, wbyte[2:0]};
					end
				end
				`SCDP_ADDR_SYS_CTRL_W: begin
					wbyte     = PWDATA[23:16];
					rdata_nxt = {8'h00, sysc_r, 16'h0000};
					if (PWRITE && PSTRB[2]) begin
						sysc_nxt = wbyte;
					end
				end
				`SCDP_ADDR_STATUS_W: begin
					rdata_nxt = {28'h0000000, illegal_r, st_r, div_sel_r == 2'b00 ? 1'b1 : 1'b0};
				end
				default: begin
					hit       = 1'b0;
					rdata_nxt = 32'h00000000;
				end
			endcase
			slverr_nxt = !hit;
		end
		if (HW_STANDBY) begin
			div_sel_nxt = 2'b00;
			mstby_nxt   = `SCDP_MOD_STBY_RST;
			sysc_nxt    = `SCDP_SYS_CTRL_RST;
		end
	end

	// ***********************************************
	// Software standby and wake wait
	// ***********************************************
	always_comb begin
		st_nxt      = st_r;
		wait_nxt    = wait_r;
		illegal_nxt = (sysc_r[`SCDP_WAIT_SEL_LSB +: 3] == 3'h7);
		case (st_r)
			SCDP_RUN: begin
				// Registers are left as they are on entry
				if (SW_STANDBY_REQ && sysc_r[7]) begin
					st_nxt = SCDP_SLEEP;
				end
			end
			SCDP_SLEEP: begin
				if (STANDBY_WAKE) begin
					st_nxt   = SCDP_SETTLE;
					wait_nxt = wait_len;
				end
			end
			SCDP_SETTLE: begin
				// Counted in divided states, so the wait stretches with the ratio
				if (sys_en) begin
					if (wait_r == 18'h00000) begin
						st_nxt = SCDP_RUN;
					end else begin
						wait_nxt = wait_r - 18'h00001;
					end
				end
			end
			default: st_nxt = SCDP_RUN;
		endcase
		if (HW_STANDBY) begin
			st_nxt   = SCDP_RUN;
			wait_nxt = 18'h00000;
		end
		// Flag registered from the next state so the pin changes with the state
		sws_nxt = (st_nxt != SCDP_RUN);
	end

	// ***********************************************
	// Clock output pin
	// ***********************************************
	always_comb begin
		clk_oe_nxt  = !mstby_r[`SCDP_CLK_OUT_STOP_BIT] && !HW_STANDBY;
		// Held high while stopped in software standby
		clk_out_nxt = (st_r == SCDP_RUN) ? sys_phase : 1'b1;
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			div_sel_r <= 2'b00;
			mstby_r   <= `SCDP_MOD_STBY_RST;
			sysc_r    <= `SCDP_SYS_CTRL_RST;
			rdata_r   <= 32'h00000000;
			ready_r   <= 1'b0;
			slverr_r  <= 1'b0;
			st_r      <= SCDP_RUN;
			wait_r    <= 18'h00000;
			clk_out_r <= 1'b0;
			clk_oe_r  <= 1'b0;
			sys_en_r  <= 1'b0;
			tick_r    <= 12'h000;
			illegal_r <= 1'b0;
			sws_r     <= 1'b0;
		end else begin
			div_sel_r <= div_sel_nxt;
			mstby_r   <= mstby_nxt;
			sysc_r    <= sysc_nxt;
			rdata_r   <= rdata_nxt;
			ready_r   <= ready_nxt;
			slverr_r  <= slverr_nxt;
			st_r      <= st_nxt;
			wait_r    <= wait_nxt;
			clk_out_r <= clk_out_nxt;
			clk_oe_r  <= clk_oe_nxt;
			sys_en_r  <= sys_en && (st_r == SCDP_RUN);
			tick_r    <= (st_r == SCDP_RUN) ? tick : 12'h000;
			illegal_r <= illegal_nxt;
			sws_r     <= sws_nxt;
		end
	end

	assign PRDATA       = rdata_r;
	assign PREADY       = ready_r;
	assign PSLVERR      = slverr_r;
	assign SYS_CLK_EN   = sys_en_r;
	assign CLK_OUT      = clk_out_r;
	assign CLK_OUT_EN   = clk_oe_r;
	assign PRESC_TICK   = tick_r;
	assign SW_STANDBY   = sws_r;
	assign WAIT_ILLEGAL = illegal_r;

endmodule : scdp_clock_gen

`default_nettype wire

// ### verification/scdp_clock_gen_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ***********************************
// Port checker
// ***********************************
module scdp_chk (
	input wire logic        CLK,
	input wire logic        RSTN,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [19:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0]  PSTRB,
	input wire logic [31:0] PRDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	input wire logic        HW_STANDBY,
	input wire logic        SW_STANDBY,
	input wire logic        SYS_CLK_EN,
	input wire logic        CLK_OUT_EN,
	input wire logic        WAIT_ILLEGAL
);
	logic [1:0] rat_r, rat_nxt;
	logic [3:0] gap_r, gap_nxt;
	logic [4:0] stb_r, stb_nxt;
	wire        acc  = PSEL && PENABLE && PREADY && !PSLVERR;
	wire        wdiv = acc && PWRITE && PADDR == 20'hEE018 && PSTRB[3];
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);
	// Rate is judged only once the ratio has been steady long enough to pass a boundary
	always_comb begin
		rat_nxt = HW_STANDBY ? 2'h0 : wdiv ? PWDATA[25:24] : rat_r;
		gap_nxt = SYS_CLK_EN ? 4'h0 : gap_r + 4'h1;
		stb_nxt = (HW_STANDBY || SW_STANDBY || wdiv) ? 5'h00 : stb_r + {4'h0, ~&stb_r};
	end
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			rat_r <= 2'h0;
			gap_r <= 4'h0;
			stb_r <= 5'h00;
		end else begin
			rat_r <= rat_nxt;
			gap_r <= gap_nxt;
			stb_r <= stb_nxt;
		end
	end
	AST_RDY_LAT: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
		else $error("ready late");
	AST_RDY_PULSE: assert property (PREADY |=> !PREADY)
		else $error("ready held");
	AST_DIV_RD: assert property (acc && !PWRITE && PADDR == 20'hEE018 |-> PRDATA[31:24] == {6'h3F, rat_r})
		else $error("ratio read");
	AST_ERR_DATA: assert property (PREADY && PSLVERR |-> PRDATA == 32'h0)
		else $error("error data");
	AST_RATE: assert property (SYS_CLK_EN && stb_r == 5'h1F |-> gap_r == (4'h1 << rat_r) - 4'h1)
		else $error("rate");
	AST_HW_OUT: assert property (HW_STANDBY |=> !CLK_OUT_EN)
		else $error("out on in hw standby");
	AST_STOP: assert property (acc && PWRITE && PADDR == 20'hEE01C && PSTRB[0] && PWDATA[7] |-> ##[1:2] !CLK_OUT_EN)
		else $error("out not stopped");
	AST_ILL: assert property (acc && PWRITE && PADDR == 20'hEE010 && PSTRB[2] && &PWDATA[22:20] |-> ##[1:2] WAIT_ILLEGAL)
		else $error("no illegal flag");
endmodule : scdp_chk
bind scdp_clock_gen scdp_chk u_scdp_chk (.CLK(CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
	.PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
	.HW_STANDBY(HW_STANDBY), .SW_STANDBY(SW_STANDBY), .SYS_CLK_EN(SYS_CLK_EN), .CLK_OUT_EN(CLK_OUT_EN),
	.WAIT_ILLEGAL(WAIT_ILLEGAL));
`default_nettype wire

// ### verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ***********************************
// Register level bench
// ***********************************
module tb;
	logic        clk = 1'b0;
	logic        rstn, psel, pen, pwr, hws, req, wake, er;
	logic [19:0] paddr;
	logic [31:0] pwdata, rd, prdata;
	logic [3:0]  pstrb;
	logic        prdy, perr, en, cko, ckoe, sws, ill;
	logic [11:0] tick;
	int          error_cnt, n_checks, n;
	wire  [12:0] pv = {en, tick};
	always #2.5 clk = ~clk;
	scdp_clock_gen u_scdp_clock_gen (.CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
		.PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(prdy), .PSLVERR(perr),
		.HW_STANDBY(hws), .SW_STANDBY_REQ(req), .STANDBY_WAKE(wake), .OSC_FAST(1'b1), .SYS_CLK_EN(en),
		.CLK_OUT(cko), .CLK_OUT_EN(ckoe), .PRESC_TICK(tick), .SW_STANDBY(sws), .WAIT_ILLEGAL(ill));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
		end
	endtask : chk
	// Reads after an edge see the values sampled at that edge
	task automatic xfer(input logic w, input logic [19:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (prdy !== 1'b1) @(posedge clk);
		rd = prdata;
		er = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : xfer
	task automatic per(input int b, input int e);
		int c;
		c = 1;
		while (pv[b] !== 1'b1) @(posedge clk);
		@(posedge clk);
		while (pv[b] !== 1'b1) begin
			c++;
			@(posedge clk);
		end
		chk(c, e);
	endtask : per
	// Output pin over 16 cycles: half of them high, one rising edge per system period
	task automatic out_chk(input int r);
		int   hi;
		int   rise;
		logic prev;
		hi = 0;
		rise = 0;
		prev = cko;
		repeat (16) begin
			@(posedge clk);
			hi += cko;
			rise += (cko && !prev);
			prev = cko;
		end
		chk(hi, 8);
		chk(rise, 16 >> r);
	endtask : out_chk
	task automatic conclude;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : conclude
	initial begin
		#200000;
		error_cnt++;
		conclude();
	end
	initial begin
		{rstn, psel, pen, pwr, hws, req, wake} = 7'h00;
		paddr = 20'h0;
		pwdata = 32'h0;
		pstrb = 4'h0;
		// Settle hold scaled down: the modelled oscillator is stable from time zero
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		xfer(1'b0, 20'hEE018, 32'h0, 4'h0);
		chk(rd[31:24], 8'hFC);
		xfer(1'b0, 20'hEE01C, 32'h0, 4'h0);
		chk(rd[7:0], 8'h78);
		chk(ckoe, 1'b1);
		$display("reset test done");
		// Fast ratio last so the slowest tick stays short; every ratio stays far above 1 MHz here
		for (int r = 3; r >= 0; r--) begin
			xfer(1'b1, 20'hEE018, {6'h00, r[1:0], 24'h0}, 4'hF);
			xfer(1'b0, 20'hEE018, 32'h0, 4'h0);
			chk(rd[31:24], {6'h3F, r[1:0]});
			per(12, 1 << r);
			per(0, 2 << r);
			if (r > 0) out_chk(r);
		end
		per(11, 4096);
		$display("ratio test done");
		xfer(1'b1, 20'hEE01C, 32'h80, 4'h1);
		repeat (2) @(posedge clk);
		chk(ckoe, 1'b0);
		xfer(1'b0, 20'hEE01C, 32'h0, 4'h0);
		chk(rd[7:0], 8'hF8);
		xfer(1'b1, 20'hEE01C, 32'h0, 4'h1);
		repeat (2) @(posedge clk);
		chk(ckoe, 1'b1);
		$display("clock out test done");
		xfer(1'b1, 20'hEE018, 32'h0200_0000, 4'h8);
		xfer(1'b1, 20'hEE010, 32'h00E0_0000, 4'h4);
		req <= 1'b1;
		@(posedge clk);
		req <= 1'b0;
		repeat (4) @(posedge clk);
		chk(sws, 1'b1);
		wake <= 1'b1;
		@(posedge clk);
		wake <= 1'b0;
		n = 0;
		while (sws === 1'b1) begin
			n++;
			@(posedge clk);
		end
		// 1024 states of four cycles; the first state may already be partly gone
		chk(n >= 4094 && n <= 4097, 1'b1);
		xfer(1'b0, 20'hEE018, 32'h0, 4'h0);
		chk(rd[31:24], 8'hFE);
		$display("standby test done");
		xfer(1'b1, 20'hEE010, 32'h0070_0000, 4'h4);
		repeat (2) @(posedge clk);
		chk(ill, 1'b1);
		hws <= 1'b1;
		repeat (3) @(posedge clk);
		chk(ckoe, 1'b0);
		hws <= 1'b0;
		xfer(1'b0, 20'hEE018, 32'h0, 4'h0);
		chk(rd[31:24], 8'hFC);
		chk(ill, 1'b0);
		xfer(1'b0, 20'hEE030, 32'h0, 4'h0);
		chk(er, 1'b1);
		chk(rd, 32'h0);
		$display("hardware standby test done");
		conclude();
	end
endmodule : tb
`default_nettype wire
